// ---- hdl/esrc_event_status.sv ----
// Read-to-clear event status register with active-low interrupt output
//
// Behaviour
// - Reading the event register clears only the bits it returned, to zero.
// - Interrupt released at the chip-select rising edge ending that read if no event remains.
// - Event register at offset 2h, resets to 1h: power-on flag only.
// - Bits 23-14 read zero; bits 13-0 clear when read.
// - Factory trim load error sets bit 13.
// - Failed post-load self-check sets bit 13 with the power-on flag.
// - Enabled converter self-diagnostic fault sets bit 12.
// - Enabled wetting current diagnostic fault sets bit 11.
// - Finished checksum calculation sets bit 8; zero while idle or running.
// - Supply low event sets bit 7; supply high event sets bit 6.
// - Supply window changes set bits 10 and 9 when measurement enabled.
`timescale 1ns/1ps
`include "esrc_regs.svh"
module esrc_event_status
(
  // Clock and reset
  input  wire logic                 MCLK,
  input  wire logic                 RESET_N,
  // Register read request from the serial front end
  input  wire logic                 READ_STROBE,
  input  wire esrc_pkg::esrc_addr_t READ_ADDR,
  // Chip select pin
  input  wire logic                 CS_N,
  // Event pulses from device functions
  input  wire logic                 FACTORY_LOAD_ERROR,
  input  wire logic                 SELFCHECK_FAIL,
  input  wire logic                 CONVERTER_SELFTEST_ERROR,
  input  wire logic                 CONVERTER_DIAG_ENABLE,
  input  wire logic                 WETTING_SOURCE_FAULT,
  input  wire logic                 WETTING_DIAG_ENABLE,
  input  wire logic                 CHECKSUM_DONE,
  input  wire logic                 SUPPLY_LOW_EVENT,
  input  wire logic                 SUPPLY_HIGH_EVENT,
  input  wire logic                 SUPPLY_WINDOW_A_CHANGE,
  input  wire logic                 SUPPLY_WINDOW_B_CHANGE,
  input  wire logic                 SUPPLY_MEASURE_ENABLE,
  input  wire logic                 THERMAL_WARNING_EVENT,
  input  wire logic                 THERMAL_SHUTDOWN_EVENT,
  input  wire logic                 SWITCH_STATE_CHANGE,
  input  wire logic                 PARITY_ERROR,
  input  wire logic                 SPI_ERROR,
  // Read data and interrupt
  output esrc_pkg::esrc_word_t      READ_DATA,
  output logic                      INT_N
);
  import esrc_pkg::*;

  esrc_events_t status;
  esrc_events_t set_mask;
  esrc_events_t next_status;
  logic         cs_sync;
  logic         cs_prev;
  logic         clear_pending;
  logic         cs_rise;
  esrc_events_t read_mask;
  esrc_events_t survivors;

  esrc_sync u_cs_sync
  (
    .clk     (MCLK),
    .reset_n (RESET_N),
    .d       (CS_N),
    .q       (cs_sync)
  );

  assign cs_rise = cs_sync & ~cs_prev;

  always_ff @(posedge MCLK or negedge RESET_N)
  begin
    if (!RESET_N)
      cs_prev <= 1'b1;
    else
      cs_prev <= cs_sync;
  end

  // Event sources into their bit positions
  always_comb
  begin
    set_mask = '0;
    set_mask[`ESRC_BIT_FACTORY] = FACTORY_LOAD_ERROR | SELFCHECK_FAIL;
    set_mask[`ESRC_BIT_POWER_ON] = SELFCHECK_FAIL;
    set_mask[`ESRC_BIT_CONVERTER] =
      CONVERTER_SELFTEST_ERROR & CONVERTER_DIAG_ENABLE;
    set_mask[`ESRC_BIT_WETTING] = WETTING_SOURCE_FAULT & WETTING_DIAG_ENABLE;
    set_mask[`ESRC_BIT_CHECKSUM] = CHECKSUM_DONE;
    set_mask[`ESRC_BIT_SUPPLY_LOW] = SUPPLY_LOW_EVENT;
    set_mask[`ESRC_BIT_SUPPLY_HIGH] = SUPPLY_HIGH_EVENT;
    set_mask[`ESRC_BIT_WINDOW_A] =
      SUPPLY_WINDOW_A_CHANGE & SUPPLY_MEASURE_ENABLE;
    set_mask[`ESRC_BIT_WINDOW_B] =
      SUPPLY_WINDOW_B_CHANGE & SUPPLY_MEASURE_ENABLE;
    set_mask[`ESRC_BIT_THERM_WARN] = THERMAL_WARNING_EVENT;
    set_mask[`ESRC_BIT_THERM_SHUT] = THERMAL_SHUTDOWN_EVENT;
    set_mask[`ESRC_BIT_SWITCH] = SWITCH_STATE_CHANGE;
    set_mask[`ESRC_BIT_PARITY] = PARITY_ERROR;
    set_mask[`ESRC_BIT_SPI_ERROR] = SPI_ERROR;
  end

  // Read of the event register arms a clear for the frame end
  always_ff @(posedge MCLK or negedge RESET_N)
  begin
    if (!RESET_N)
      clear_pending <= 1'b0;
    else if (cs_rise)
      clear_pending <= 1'b0;
    else if (READ_STROBE && READ_ADDR == `ESRC_EVENT_STATUS_OFFSET)
      clear_pending <= 1'b1;
  end

  // Bits reported by the reads of this frame
  always_ff @(posedge MCLK or negedge RESET_N)
  begin
    if (!RESET_N)
      read_mask <= '0;
    else if (cs_rise)
      read_mask <= '0;
    else if (READ_STROBE && READ_ADDR == `ESRC_EVENT_STATUS_OFFSET)
      read_mask <= read_mask | status;
  end

  assign survivors = (status & ~read_mask) | set_mask;

  // Events latch; frame end clears only what was read
  always_comb
  begin
    next_status = status | set_mask;
    if (cs_rise && clear_pending)
      next_status = survivors;
  end

  always_ff @(posedge MCLK or negedge RESET_N)
  begin
    if (!RESET_N)
      status <= esrc_events_t'(`ESRC_EVENT_STATUS_RESET);
    else
      status <= next_status;
  end

  // upper bits zero in read data
  always_ff @(posedge MCLK or negedge RESET_N)
  begin
    if (!RESET_N)
      READ_DATA <= '0;
    else if (READ_STROBE && READ_ADDR == `ESRC_EVENT_STATUS_OFFSET)
      READ_DATA <= {10'h000, status};
    else if (READ_STROBE)
      READ_DATA <= '0;
  end

  always_ff @(posedge MCLK or negedge RESET_N)
  begin
    if (!RESET_N)
      INT_N <= 1'b1;
    else
      INT_N <= ~(|next_status);
  end

  // Frame end with nothing left to keep
  sequence s_clean_clear;
    cs_rise && clear_pending && survivors == '0;
  endsequence

  property p_clear;
    @(posedge MCLK) disable iff (!RESET_N)
    s_clean_clear |=> status == '0;
  endproperty
  a_clear: assert property (p_clear)
    else $error("read clear missed");

  property p_int_release;
    @(posedge MCLK) disable iff (!RESET_N)
    s_clean_clear |=> INT_N;
  endproperty
  a_int_release: assert property (p_int_release)
    else $error("int held");

  property p_reserved;
    @(posedge MCLK) disable iff (!RESET_N)
    READ_DATA[23:14] == 10'h000;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved set");

  property p_selfcheck;
    @(posedge MCLK) disable iff (!RESET_N)
    SELFCHECK_FAIL |=> status[`ESRC_BIT_FACTORY] && status[`ESRC_BIT_POWER_ON];
  endproperty
  a_selfcheck: assert property (p_selfcheck)
    else $error("selfcheck");

  property p_converter;
    @(posedge MCLK) disable iff (!RESET_N)
    (CONVERTER_SELFTEST_ERROR && CONVERTER_DIAG_ENABLE)
      |=> status[`ESRC_BIT_CONVERTER];
  endproperty
  a_converter: assert property (p_converter)
    else $error("converter");

  property p_wetting;
    @(posedge MCLK) disable iff (!RESET_N)
    (!status[`ESRC_BIT_WETTING] && !WETTING_DIAG_ENABLE)
      |=> !status[`ESRC_BIT_WETTING];
  endproperty
  a_wetting: assert property (p_wetting)
    else $error("wetting");

  property p_window;
    @(posedge MCLK) disable iff (!RESET_N)
    (SUPPLY_WINDOW_A_CHANGE && SUPPLY_MEASURE_ENABLE)
      |=> status[`ESRC_BIT_WINDOW_A];
  endproperty
  a_window: assert property (p_window)
    else $error("window a");

  sequence s_clear_with_event;
    cs_rise && clear_pending && survivors != '0;
  endsequence
  property p_keep;
    @(posedge MCLK) disable iff (!RESET_N)
    s_clear_with_event |=>
      ((status & $past(survivors)) == $past(survivors)) ##1 !INT_N;
  endproperty
  a_keep: assert property (p_keep)
    else $error("event lost");
endmodule

// ---- hdl/esrc_sync.sv ----
// Two-flop synchroniser for one pin level
`timescale 1ns/1ps
module esrc_sync
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic reset_n,
  // Level
  input  wire logic d,
  output logic      q
);
  logic stage1;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      // Idle high level, so no false edge follows reset
      stage1 <= 1'b1;
      q      <= 1'b1;
    end
    else
    begin
      stage1 <= d;
      q      <= stage1;
    end
  end
endmodule

// ---- shared/esrc_pkg.sv ----
// Types shared by the event status block
package esrc_pkg;
  typedef logic [13:0] esrc_events_t;
  typedef logic [23:0] esrc_word_t;
  typedef logic [5:0]  esrc_addr_t;
endpackage

// ---- shared/esrc_regs.svh ----
// Register offsets, field positions and reset values of the event status block
`ifndef ESRC_REGS_SVH
`define ESRC_REGS_SVH
`define ESRC_EVENT_STATUS_OFFSET 6'h02
`define ESRC_EVENT_STATUS_RESET  24'h000001
`define ESRC_BIT_POWER_ON        0
`define ESRC_BIT_SPI_ERROR       1
`define ESRC_BIT_PARITY          2
`define ESRC_BIT_SWITCH          3
`define ESRC_BIT_THERM_SHUT      4
`define ESRC_BIT_THERM_WARN      5
`define ESRC_BIT_SUPPLY_HIGH     6
`define ESRC_BIT_SUPPLY_LOW      7
`define ESRC_BIT_CHECKSUM        8
`define ESRC_BIT_WINDOW_A        9
`define ESRC_BIT_WINDOW_B        10
`define ESRC_BIT_WETTING         11
`define ESRC_BIT_CONVERTER       12
`define ESRC_BIT_FACTORY         13
`define ESRC_EVENT_BITS          14
`define ESRC_REG_WIDTH           24
`endif

// ---- verif/esrc_host.sv ----
// Host model that frames register reads with chip select
`timescale 1ns/1ps
module esrc_host
(
  // Clock
  input  wire logic                 MCLK,
  // Read answer
  input  wire esrc_pkg::esrc_word_t READ_DATA,
  // Read request
  output logic                      CS_N,
  output logic                      READ_STROBE,
  output esrc_pkg::esrc_addr_t      READ_ADDR
);
  import esrc_pkg::*;
  initial
  begin
    CS_N = 1'b1;
    READ_STROBE = 1'b0;
    READ_ADDR = 6'h3F;
  end
  // Address shows its inverse once released
  task automatic read_frame(input esrc_addr_t a, output esrc_word_t d);
    @(posedge MCLK) #5 CS_N = 1'b0;
    @(posedge MCLK) #5 READ_STROBE = 1'b1;
    READ_ADDR = a;
    @(posedge MCLK) #5 READ_STROBE = 1'b0;
    READ_ADDR = ~a;
    d = READ_DATA;
    @(posedge MCLK) #5 CS_N = 1'b1;
  endtask
endmodule

// ---- verif/tb.sv ----
// Testbench for the read-to-clear event status register
`timescale 1ns/1ps
module tb;
  import esrc_pkg::*;
  logic        mclk, reset_n, selfchk, gate, cs_n, strobe, int_n;
  logic [13:0] evt;
  esrc_addr_t  addr;
  esrc_word_t  rdata, d;
  int          n_fail, checked, cyc;
  esrc_event_status dut (.MCLK(mclk), .RESET_N(reset_n),
    .READ_STROBE(strobe), .READ_ADDR(addr), .CS_N(cs_n),
    .FACTORY_LOAD_ERROR(evt[13]), .SELFCHECK_FAIL(selfchk),
    .CONVERTER_SELFTEST_ERROR(evt[12]), .CONVERTER_DIAG_ENABLE(gate),
    .WETTING_SOURCE_FAULT(evt[11]), .WETTING_DIAG_ENABLE(gate),
    .CHECKSUM_DONE(evt[8]), .SUPPLY_LOW_EVENT(evt[7]),
    .SUPPLY_HIGH_EVENT(evt[6]), .SUPPLY_WINDOW_A_CHANGE(evt[9]),
    .SUPPLY_WINDOW_B_CHANGE(evt[10]), .SUPPLY_MEASURE_ENABLE(gate),
    .THERMAL_WARNING_EVENT(evt[5]), .THERMAL_SHUTDOWN_EVENT(evt[4]),
    .SWITCH_STATE_CHANGE(evt[3]), .PARITY_ERROR(evt[2]),
    .SPI_ERROR(evt[1]), .READ_DATA(rdata), .INT_N(int_n));
  esrc_host host (.MCLK(mclk), .READ_DATA(rdata), .CS_N(cs_n),
    .READ_STROBE(strobe), .READ_ADDR(addr));
  task automatic chk_word(input esrc_word_t exp, input esrc_word_t got);
    checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR %0t word %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_int(input logic exp);
    checked++;
    if (int_n !== exp)
    begin
      n_fail++;
      $display("ERROR %0t interrupt %b expected %b", $time, int_n, exp);
    end
  endtask
  task automatic fire(input int i);
    @(posedge mclk) #5 evt[i] = 1'b1;
    @(posedge mclk) #5 evt[i] = 1'b0;
  endtask
  // Read, check, then let the clear after chip select land
  task automatic rd_chk(input esrc_word_t exp);
    host.read_frame(6'h02, d);
    chk_word(exp, d);
    repeat (5) @(posedge mclk);
    #5;
  endtask
  task report_and_stop;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc > 5000)
    begin
      n_fail++;
      report_and_stop();
    end
  end
  initial
  begin
    reset_n = 1'b0;
    selfchk = 1'b0;
    gate = 1'b1;
    evt = '0;
    n_fail = 0;
    checked = 0;
    cyc = 0;
    repeat (8) @(posedge mclk);
    #5 reset_n = 1'b1;
    repeat (2) @(posedge mclk);
    #5 chk_int(1'b0);
    rd_chk(24'h000001);
    chk_int(1'b1);
    rd_chk(24'h000000);
    for (int i = 1; i < 14; i++)
    begin
      fire(i);
      rd_chk(24'h000001 << i);
      chk_int(1'b1);
      rd_chk(24'h000000);
    end
    gate = 1'b0;
    for (int i = 9; i < 13; i++)
      fire(i);
    gate = 1'b1;
    rd_chk(24'h000000);
    @(posedge mclk) #5 selfchk = 1'b1;
    @(posedge mclk) #5 selfchk = 1'b0;
    rd_chk(24'h002001);
    // Event lands in the same cycle as the read, inside the frame
    fork
      host.read_frame(6'h02, d);
      begin
        @(posedge mclk);
        fire(3);
      end
    join
    chk_word(24'h000000, d);
    repeat (5) @(posedge mclk);
    #5 chk_int(1'b0);
    rd_chk(24'h000008);
    // Read of another offset neither shows nor clears events
    fire(5);
    host.read_frame(6'h04, d);
    chk_word(24'h000000, d);
    repeat (5) @(posedge mclk);
    rd_chk(24'h000020);
    fire(13);
    rd_chk(24'h002000);
    // Host answers the load error with a fresh reset
    reset_n = 1'b0;
    repeat (2) @(posedge mclk);
    #5 reset_n = 1'b1;
    repeat (2) @(posedge mclk);
    rd_chk(24'h000001);
    report_and_stop();
  end
endmodule
